// ==== rlt_pkg.sv ====
// rlt_pkg: constants shared by the receiver-1 loss threshold register block
package rlt_pkg;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] OFS_RANGE = 8'hbc;
    localparam logic [7:0] OFS_RSVD  = 8'hbd;
    localparam logic [7:0] OFS_HIGH  = 8'hbe;
    localparam logic [7:0] OFS_LOW   = 8'hbf;

    // ********************************
    // two-wire slave addresses (7-bit forms of a2h and b2h)
    // ********************************
    localparam logic [6:0] SLAVE_ADDR_MAIN = 7'h51;
    localparam logic [6:0] SLAVE_ADDR_AUX  = 7'h59;

    // ********************************
    // field layout and reset values
    // ********************************
    localparam int          HIGH_SEL_MSB     = 6;
    localparam int          HIGH_SEL_LSB     = 4;
    localparam int          LOW_SEL_MSB      = 2;
    localparam int          LOW_SEL_LSB      = 0;
    localparam logic [7:0]  RANGE_WRITE_MASK = 8'h77;
    localparam logic [7:0]  FACTORY_DEFAULT  = 8'h00;
    localparam logic [7:0]  DENIED_READ      = 8'h00;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0]  BIT_COUNT_ZERO   = 4'h0;
    localparam logic [2:0]  TX_MSB           = 3'h7;

    // ********************************
    // bus state machine
    // ********************************
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_PTR,
        ST_ACK_PTR,
        ST_WR,
        ST_ACK_WR,
        ST_RD,
        ST_ACK_RD
    } rlt_state_type;

endpackage

// ==== rlt_sync.sv ====
// rlt_sync: two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
module rlt_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // pins and synchronised copy
    input  wire logic [WIDTH-1:0] rawLevel,
    output logic      [WIDTH-1:0] syncLevel
);

    logic [WIDTH-1:0] stageOne_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stageOne_q <= RESET_VALUE;
            syncLevel  <= RESET_VALUE;
        end else begin
            stageOne_q <= rawLevel;
            syncLevel  <= stageOne_q;
        end
    end

endmodule

// ==== rlt_hyst.sv ====
// rlt_hyst: hysteresis comparator producing the loss low and high alarms
`timescale 1ns/1ps
module rlt_hyst #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // level and thresholds
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] highLevel,
    input  wire logic [WIDTH-1:0] lowLevel,
    // alarms
    output logic                  lossLowAlarm,
    output logic                  lossHighAlarm
);

    // falling under low wins if thresholds are crossed over
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lossLowAlarm  <= 1'b0;
            lossHighAlarm <= 1'b0;
        end else if (level < lowLevel) begin
            lossLowAlarm  <= 1'b1;
            lossHighAlarm <= 1'b0;
        end else if (level > highLevel) begin
            lossLowAlarm  <= 1'b0;
            lossHighAlarm <= 1'b1;
        end
    end

endmodule

// ==== rlt_regs.sv ====
// rlt_regs: receiver-1 loss threshold registers behind the two-wire slave
`timescale 1ns/1ps
module rlt_regs #(
    parameter int DATA_WIDTH = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // two-wire serial pins
    input  wire logic                  sclPin,
    input  wire logic                  sdaPin,
    output logic                       sdaDrive,
    output logic                       sdaOe,
    // password block
    input  wire logic                  password_level_one,
    input  wire logic                  password_level_top,
    input  wire logic                  table_rw_permit,
    input  wire logic                  table_read_permit,
    input  wire logic                  quick_trip_enable,
    // receiver-1 monitor
    input  wire logic [DATA_WIDTH-1:0] rx1_signal_strength,
    output logic      [2:0]            high_range_sel,
    output logic      [2:0]            low_range_sel,
    output logic      [DATA_WIDTH-1:0] high_loss_threshold,
    output logic      [DATA_WIDTH-1:0] low_loss_threshold,
    output logic                       rx1_signal_loss_low,
    output logic                       rx1_signal_loss_high
);

    // ********************************
    // declarations
    // ********************************
    logic                  sclSync;
    logic                  sdaSync;
    logic                  sclPrev_q;
    logic                  sdaPrev_q;
    logic                  startSeen;
    logic                  stopSeen;
    logic                  sclRise;
    logic                  sclFall;
    rlt_pkg::rlt_state_type state_q;
    logic [3:0]            bitCnt_q;
    logic [7:0]            shift_q;
    logic [7:0]            ptr_q;
    logic [7:0]            tx_q;
    logic                  byteFull;
    logic                  addrMatch;
    logic                  writeFire;
    logic                  readOk;
    logic                  writeOk;
    logic                  thresholdWriteOk;
    logic [7:0]            range_q;
    logic [DATA_WIDTH-1:0] high_q;
    logic [DATA_WIDTH-1:0] low_q;
    logic [7:0]            readNow;
    logic [7:0]            readNext;

    // ********************************
    // register read decode
    // ********************************
    function automatic logic [7:0] regRead(
        input logic [7:0]            addr,
        input logic                  allowed,
        input logic [7:0]            rangeVal,
        input logic [DATA_WIDTH-1:0] highVal,
        input logic [DATA_WIDTH-1:0] lowVal
    );
        logic [7:0] value;
        value = rlt_pkg::DENIED_READ;
        if (allowed) begin
            unique case (addr)
                rlt_pkg::OFS_RANGE: value = rangeVal;
                rlt_pkg::OFS_HIGH:  value = 8'(highVal);
                rlt_pkg::OFS_LOW:   value = 8'(lowVal);
                default:            value = rlt_pkg::DENIED_READ;
            endcase
        end
        return value;
    endfunction

    // pointer step, wraps at 8 bits
    function automatic logic [7:0] nextPtr(input logic [7:0] ptr);
        return 8'(ptr + 8'h01);
    endfunction

    function automatic logic isDataPhase(input rlt_pkg::rlt_state_type st);
        return st == rlt_pkg::ST_ADDR || st == rlt_pkg::ST_PTR
            || st == rlt_pkg::ST_WR || st == rlt_pkg::ST_RD;
    endfunction

    function automatic logic isAckPhase(input rlt_pkg::rlt_state_type st);
        return st == rlt_pkg::ST_ACK_ADDR || st == rlt_pkg::ST_ACK_PTR
            || st == rlt_pkg::ST_ACK_WR || st == rlt_pkg::ST_ACK_RD;
    endfunction

    // ********************************
    // pin synchronisers
    // ********************************
    // idle-high reset keeps a false start away after reset
    rlt_sync #(
        .WIDTH       (1),
        .RESET_VALUE (1'b1)
    ) u_sclSync (
        .core_clk  (core_clk),
        .rst       (rst),
        .rawLevel  (sclPin),
        .syncLevel (sclSync)
    );

    rlt_sync #(
        .WIDTH       (1),
        .RESET_VALUE (1'b1)
    ) u_sdaSync (
        .core_clk  (core_clk),
        .rst       (rst),
        .rawLevel  (sdaPin),
        .syncLevel (sdaSync)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclSync;
            sdaPrev_q <= sdaSync;
        end
    end

    // ********************************
    // start and stop detection
    // ********************************
    assign startSeen = sclSync & sdaPrev_q & ~sdaSync;
    assign stopSeen  = sclSync & ~sdaPrev_q & sdaSync;
    assign sclRise   = sclSync & ~sclPrev_q;
    assign sclFall   = ~sclSync & sclPrev_q;
    assign byteFull  = (bitCnt_q == rlt_pkg::BITS_PER_BYTE);

    // both slave addresses reach the same storage
    assign addrMatch = (shift_q[7:1] == rlt_pkg::SLAVE_ADDR_MAIN)
                     | (shift_q[7:1] == rlt_pkg::SLAVE_ADDR_AUX);

    // ********************************
    // access permissions
    // ********************************
    assign readOk = password_level_top
                  | (password_level_one & (table_rw_permit | table_read_permit));
    assign writeOk = password_level_top
                   | (password_level_one & table_rw_permit);
    assign thresholdWriteOk = writeOk & ~quick_trip_enable;

    assign readNow  = regRead(ptr_q, readOk, range_q, high_q, low_q);
    assign readNext = regRead(nextPtr(ptr_q), readOk, range_q, high_q, low_q);

    // ********************************
    // bus state machine
    // ********************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= rlt_pkg::ST_IDLE;
        end else if (startSeen) begin
            state_q <= rlt_pkg::ST_ADDR;
        end else if (stopSeen) begin
            state_q <= rlt_pkg::ST_IDLE;
        // master nack ends the read before the next fall
        end else if (sclRise && state_q == rlt_pkg::ST_ACK_RD && sdaSync) begin
            state_q <= rlt_pkg::ST_IDLE;
        end else if (sclFall) begin
            unique case (state_q)
                rlt_pkg::ST_IDLE:     state_q <= rlt_pkg::ST_IDLE;
                rlt_pkg::ST_ADDR: begin
                    if (byteFull) begin
                        state_q <= addrMatch ? rlt_pkg::ST_ACK_ADDR : rlt_pkg::ST_IDLE;
                    end
                end
                rlt_pkg::ST_ACK_ADDR: state_q <= shift_q[0] ? rlt_pkg::ST_RD : rlt_pkg::ST_PTR;
                rlt_pkg::ST_PTR: begin
                    if (byteFull) begin
                        state_q <= rlt_pkg::ST_ACK_PTR;
                    end
                end
                rlt_pkg::ST_ACK_PTR:  state_q <= rlt_pkg::ST_WR;
                rlt_pkg::ST_WR: begin
                    if (byteFull) begin
                        state_q <= rlt_pkg::ST_ACK_WR;
                    end
                end
                rlt_pkg::ST_ACK_WR:   state_q <= rlt_pkg::ST_WR;
                rlt_pkg::ST_RD: begin
                    if (byteFull) begin
                        state_q <= rlt_pkg::ST_ACK_RD;
                    end
                end
                rlt_pkg::ST_ACK_RD:   state_q <= rlt_pkg::ST_RD;
                default:              state_q <= rlt_pkg::ST_IDLE;
            endcase
        end
    end

    // ********************************
    // bit counter and receive shifter
    // ********************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bitCnt_q <= rlt_pkg::BIT_COUNT_ZERO;
            shift_q  <= 8'h00;
        end else if (startSeen) begin
            bitCnt_q <= rlt_pkg::BIT_COUNT_ZERO;
        end else if (sclRise && !byteFull && isDataPhase(state_q)) begin
            bitCnt_q <= bitCnt_q + 4'h1;
            shift_q  <= {shift_q[6:0], sdaSync};
        end else if (sclFall && isAckPhase(state_q)) begin
            bitCnt_q <= rlt_pkg::BIT_COUNT_ZERO;
        end
    end

    // ********************************
    // register pointer and transmit byte
    // ********************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr_q <= 8'h00;
            tx_q  <= 8'h00;
        end else if (sclFall) begin
            if (state_q == rlt_pkg::ST_PTR && byteFull) begin
                ptr_q <= shift_q;
            end else if (writeFire) begin
                ptr_q <= nextPtr(ptr_q);
            end else if (state_q == rlt_pkg::ST_ACK_ADDR) begin
                tx_q <= readNow;
            end else if (state_q == rlt_pkg::ST_ACK_RD) begin
                // read-ahead so the next msb is ready at the ack fall
                ptr_q <= nextPtr(ptr_q);
                tx_q  <= readNext;
            end
        end
    end

    // ********************************
    // data line driver
    // ********************************
    // open drain: the pin is only ever pulled low
    assign sdaDrive = 1'b0;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdaOe <= 1'b0;
        end else if (startSeen || stopSeen) begin
            sdaOe <= 1'b0;
        end else if (sclFall) begin
            unique case (state_q)
                rlt_pkg::ST_ADDR:     sdaOe <= byteFull & addrMatch;
                rlt_pkg::ST_PTR:      sdaOe <= byteFull;
                rlt_pkg::ST_WR:       sdaOe <= byteFull;
                rlt_pkg::ST_ACK_ADDR: sdaOe <= shift_q[0] & ~readNow[rlt_pkg::TX_MSB];
                rlt_pkg::ST_ACK_RD:   sdaOe <= ~readNext[rlt_pkg::TX_MSB];
                rlt_pkg::ST_RD: begin
                    if (byteFull) begin
                        sdaOe <= 1'b0;
                    end else begin
                        sdaOe <= ~tx_q[3'(rlt_pkg::TX_MSB - 3'(bitCnt_q))];
                    end
                end
                default:              sdaOe <= 1'b0;
            endcase
        end
    end

    // ********************************
    // register storage, reloaded with the factory default on reset
    // ********************************
    // refused writes are still acked, then dropped
    assign writeFire = sclFall && state_q == rlt_pkg::ST_WR && byteFull;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            range_q <= rlt_pkg::FACTORY_DEFAULT;
            high_q  <= DATA_WIDTH'(rlt_pkg::FACTORY_DEFAULT);
            low_q   <= DATA_WIDTH'(rlt_pkg::FACTORY_DEFAULT);
        end else if (writeFire) begin
            unique case (ptr_q)
                rlt_pkg::OFS_RANGE: begin
                    if (writeOk) begin
                        range_q <= shift_q & rlt_pkg::RANGE_WRITE_MASK;
                    end
                end
                rlt_pkg::OFS_HIGH: begin
                    if (thresholdWriteOk) begin
                        high_q <= DATA_WIDTH'(shift_q);
                    end
                end
                rlt_pkg::OFS_LOW: begin
                    if (thresholdWriteOk) begin
                        low_q <= DATA_WIDTH'(shift_q);
                    end
                end
                default: ;
            endcase
        end
    end

    // ********************************
    // register outputs
    // ********************************
    assign high_range_sel      = range_q[rlt_pkg::HIGH_SEL_MSB:rlt_pkg::HIGH_SEL_LSB];
    assign low_range_sel       = range_q[rlt_pkg::LOW_SEL_MSB:rlt_pkg::LOW_SEL_LSB];
    assign high_loss_threshold = high_q;
    assign low_loss_threshold  = low_q;

    // ********************************
    // hysteresis comparator
    // ********************************
    rlt_hyst #(
        .WIDTH (DATA_WIDTH)
    ) u_hyst (
        .core_clk      (core_clk),
        .rst           (rst),
        .level         (rx1_signal_strength),
        .highLevel     (high_q),
        .lowLevel      (low_q),
        .lossLowAlarm  (rx1_signal_loss_low),
        .lossHighAlarm (rx1_signal_loss_high)
    );

endmodule

// ==== rlt_regs_chk.sv ====
// rlt_regs_chk: port assertions for the loss threshold block
`timescale 1ns/1ps
module rlt_regs_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // password block
    input wire logic       password_level_one,
    input wire logic       password_level_top,
    input wire logic       table_rw_permit,
    input wire logic       quick_trip_enable,
    // monitor side
    input wire logic [7:0] rx1_signal_strength,
    input wire logic [2:0] high_range_sel,
    input wire logic [2:0] low_range_sel,
    input wire logic [7:0] high_loss_threshold,
    input wire logic [7:0] low_loss_threshold,
    input wire logic       rx1_signal_loss_low,
    input wire logic       rx1_signal_loss_high
);
    wire logic wrOk  = password_level_top || (password_level_one && table_rw_permit);
    wire logic below = rx1_signal_strength < low_loss_threshold;
    wire logic above = rx1_signal_strength > high_loss_threshold;
    wire logic lo    = rx1_signal_loss_low;
    wire logic hi    = rx1_signal_loss_high;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    low_set_a: assert property (below |=> lo && !hi)
        else $error("low alarm missed");
    high_set_a: assert property (above && !below |=> !lo && hi)
        else $error("high alarm missed");
    alarm_hold_a: assert property (!below && !above |=> $stable(lo) && $stable(hi))
        else $error("alarm moved without cause");
    alarm_excl_a: assert property (!(lo && hi))
        else $error("both alarms set");
    range_deny_a: assert property (!wrOk && !$past(wrOk) && !$past(wrOk, 2)
        |-> $stable(high_range_sel) && $stable(low_range_sel))
        else $error("range written without permit");
    thr_deny_a: assert property (!wrOk && !$past(wrOk) && !$past(wrOk, 2)
        |-> $stable(high_loss_threshold) && $stable(low_loss_threshold))
        else $error("threshold written without permit");
    thr_lock_a: assert property (quick_trip_enable && $past(quick_trip_enable)
        && $past(quick_trip_enable, 2)
        |-> $stable(high_loss_threshold) && $stable(low_loss_threshold))
        else $error("threshold written while locked");
    reset_val_a: assert property ($fell(rst) |-> high_range_sel == 3'h0
        && low_range_sel == 3'h0 && high_loss_threshold == 8'h00 && low_loss_threshold == 8'h00)
        else $error("factory value wrong");
endmodule

bind rlt_regs rlt_regs_chk i_rlt_regs_chk (
    .core_clk, .rst, .password_level_one, .password_level_top, .table_rw_permit,
    .quick_trip_enable, .rx1_signal_strength, .high_range_sel, .low_range_sel,
    .high_loss_threshold, .low_loss_threshold, .rx1_signal_loss_low, .rx1_signal_loss_high
);

// ==== rlt_host_model.sv ====
// rlt_host_model: two-wire bus master for the loss threshold block
`timescale 1ns/1ps
module rlt_host_model (
    // clock
    input  wire logic core_clk,
    // bus pins
    input  wire logic sdaOe,
    input  wire logic sdaDrive,
    output logic      sclLine,
    output wire logic sdaLine
);
    logic sdaPull;
    // released line floats high through the pull-up
    assign sdaLine = !sdaPull && (!sdaOe || sdaDrive);
    initial begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic hp(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic sd(input logic v);
        hp(8);
        sdaPull = !v;
    endtask
    task automatic sc(input logic v);
        hp(8);
        sclLine = v;
    endtask
    task automatic bitx(input logic b, output logic s);
        sd(b);
        sc(1'b1);
        hp(4);
        s = sdaLine;
        sc(1'b0);
    endtask
    task automatic start;
        sd(1'b1);
        sc(1'b1);
        sd(1'b0);
        sc(1'b0);
    endtask
    task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(1'b1, s);
        ack = !s;
    endtask
    task automatic wr(input logic [6:0] sa, input logic [7:0] p, input logic [7:0] d,
                      output logic ack);
        logic [7:0] q;
        logic       a;
        start();
        xb({sa, 1'b0}, q, ack);
        xb(p, q, a);
        xb(d, q, a);
        sd(1'b0);
        sc(1'b1);
        sd(1'b1);
    endtask
    task automatic rd(input logic [6:0] sa, input logic [7:0] p, output logic [7:0] d);
        logic [7:0] q;
        logic       a;
        start();
        xb({sa, 1'b0}, q, a);
        xb(p, q, a);
        start();
        xb({sa, 1'b1}, q, a);
        xb(8'hff, d, a);
        sd(1'b0);
        sc(1'b1);
        sd(1'b1);
    endtask
endmodule

// ==== test_rx1_loss_threshold_regs.sv ====
// test_rx1_loss_threshold_regs: self-checking bench for the loss threshold block
`timescale 1ns/1ps
module test_rx1_loss_threshold_regs;
    localparam logic [6:0] MA  = rlt_pkg::SLAVE_ADDR_MAIN;
    localparam logic [6:0] AX  = rlt_pkg::SLAVE_ADDR_AUX;
    localparam logic [7:0] RNG = rlt_pkg::OFS_RANGE;
    localparam logic [7:0] HI  = rlt_pkg::OFS_HIGH;
    localparam logic [7:0] LO  = rlt_pkg::OFS_LOW;
    logic       core_clk, rst, sclLine, sdaOe, sdaDrive, ack;
    wire logic  sdaLine;
    logic       pwOne, pwTop, rwPermit, rdPermit, quickTripEn, alarmLow, alarmHigh;
    logic [7:0] rssi, hiThr, loThr, got, cur, v;
    logic [2:0] hiSel, loSel;
    int         failures, checks;
    logic [5:0] permTab [5] = '{6'h23, 6'h1b, 6'h15, 6'h10, 6'h0c};
    logic [9:0] alarmTab [6] = '{{8'h30, 2'h2}, {8'h80, 2'h2}, {8'hc0, 2'h2},
                                 {8'hd0, 2'h1}, {8'h40, 2'h1}, {8'h3f, 2'h2}};
    rlt_regs i_rlt_regs (
        .core_clk            (core_clk),
        .rst                 (rst),
        .sclPin              (sclLine),
        .sdaPin              (sdaLine),
        .sdaDrive            (sdaDrive),
        .sdaOe               (sdaOe),
        .password_level_one  (pwOne),
        .password_level_top  (pwTop),
        .table_rw_permit     (rwPermit),
        .table_read_permit   (rdPermit),
        .quick_trip_enable   (quickTripEn),
        .rx1_signal_strength (rssi),
        .high_range_sel      (hiSel),
        .low_range_sel       (loSel),
        .high_loss_threshold (hiThr),
        .low_loss_threshold  (loThr),
        .rx1_signal_loss_low (alarmLow),
        .rx1_signal_loss_high(alarmHigh)
    );
    rlt_host_model i_rlt_host_model (.core_clk(core_clk), .sdaOe(sdaOe), .sclLine(sclLine),
                                     .sdaLine(sdaLine), .sdaDrive(sdaDrive));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic seen);
        chk_byte(nm, {7'h0, exp}, {7'h0, seen});
    endtask
    task automatic chk_outs(input logic [2:0] hs, ls, input logic [7:0] ht, lt);
        chk_byte("high range select", {5'h0, hs}, {5'h0, hiSel});
        chk_byte("low range select", {5'h0, ls}, {5'h0, loSel});
        chk_byte("high threshold", ht, hiThr);
        chk_byte("low threshold", lt, loThr);
    endtask
    task automatic set_perm(input logic [3:0] p);
        @(negedge core_clk);
        {pwTop, pwOne, rwPermit, rdPermit} = p;
    endtask
    task automatic wr(input logic [6:0] sa, input logic [7:0] ofs, input logic [7:0] d);
        i_rlt_host_model.wr(sa, ofs, d, ack);
    endtask
    task automatic rd_chk(input logic [6:0] sa, input logic [7:0] ofs, input logic [7:0] exp);
        i_rlt_host_model.rd(sa, ofs, got);
        chk_byte("read data", exp, got);
    endtask
    initial begin
        repeat (80000) @(posedge core_clk);
        failures++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        {pwTop, pwOne, rwPermit, rdPermit, quickTripEn} = 5'h00;
        rssi = 8'h80;
        failures = 0;
        checks = 0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        chk_outs(3'h0, 3'h0, 8'h00, 8'h00);
        set_perm(4'h8);
        rd_chk(MA, RNG, 8'h00);
        rd_chk(AX, HI, 8'h00);
        rd_chk(MA, LO, 8'h00);
        $display("test factory values finished");
        wr(MA, RNG, 8'hff);
        chk_bit("address ack", 1'b1, ack);
        chk_outs(3'h7, 3'h7, 8'h00, 8'h00);
        rd_chk(AX, RNG, 8'h77);
        wr(AX, RNG, 8'h25);
        chk_bit("address ack", 1'b1, ack);
        wr(MA, HI, 8'hc0);
        wr(AX, LO, 8'h40);
        chk_outs(3'h2, 3'h5, 8'hc0, 8'h40);
        rd_chk(MA, LO, 8'h40);
        wr(MA, rlt_pkg::OFS_RSVD, 8'h5a);
        rd_chk(AX, rlt_pkg::OFS_RSVD, 8'h00);
        wr(7'h50, HI, 8'h00);
        chk_bit("address ack", 1'b0, ack);
        $display("test register writes finished");
        @(negedge core_clk);
        quickTripEn = 1'b1;
        wr(MA, HI, 8'h11);
        wr(MA, LO, 8'h22);
        wr(MA, RNG, 8'h33);
        chk_outs(3'h3, 3'h3, 8'hc0, 8'h40);
        @(negedge core_clk);
        quickTripEn = 1'b0;
        $display("test quick-trip lock finished");
        cur = 8'h33;
        for (int i = 0; i < 5; i++) begin
            v = 8'h11 * 8'(i + 1);
            set_perm(permTab[i][5:2]);
            wr(MA, RNG, v);
            cur = permTab[i][1] ? v : cur;
            rd_chk(MA, RNG, permTab[i][0] ? cur : 8'h00);
            set_perm(4'h8);
            rd_chk(AX, RNG, cur);
        end
        $display("test permissions finished");
        for (int i = 0; i < 6; i++) begin
            @(negedge core_clk);
            rssi = alarmTab[i][9:2];
            repeat (3) @(negedge core_clk);
            chk_bit("low alarm", alarmTab[i][1], alarmLow);
            chk_bit("high alarm", alarmTab[i][0], alarmHigh);
        end
        $display("test alarms finished");
        close_out();
    end
endmodule
